// File: rtl/can_buffer_filter_regs_consts.vh
// register map, field positions and reset values of the buffer and filter register block
`ifndef CAN_BUFFER_FILTER_REGS_CONSTS_VH
`define CAN_BUFFER_FILTER_REGS_CONSTS_VH

// word indices (byte address = index * 4)
`define IDX_MODE       7'h00
`define IDX_DIR        7'h01
`define IDX_FEN0       7'h02
`define IDX_FEN1       7'h03
`define IDX_MSEL_BASE  7'h04
`define IDX_MSEL_LAST  7'h07
`define IDX_BPTR_BASE  7'h08
`define IDX_BPTR_LAST  7'h0f
`define IDX_LEN_BASE   7'h10
`define IDX_LEN_LAST   7'h15
`define IDX_FILT_BASE  7'h20
`define IDX_FILT_LAST  7'h5f
`define IDX_MASK_BASE  7'h60
`define IDX_MASK_LAST  7'h67

// byte within a filter or mask group
`define SUB_SIDH       2'h0
`define SUB_SIDL       2'h1
`define SUB_EIDH       2'h2
`define SUB_EIDL       2'h3

// field positions
`define LEN_RTR_BIT    6
`define IDL_EXT_BIT    3
`define IDL_WR_MASK    8'heb
`define MSKL_WR_MASK   8'he3
`define DIR_LSB        2
`define DLC_MAX        4'h8

// operating modes
`define MODE_LEGACY    2'h0
`define LEGACY_FILTERS 4'h6
`define BUF_PTR_FIRST  4'h2
`define BUF_PTR_LAST   4'h7
`define MSEL_MASK0     2'h0
`define MSEL_MASK1     2'h1
`define MSEL_FILT15    2'h2
`define MSEL_NONE      2'h3

// reset values of control registers
`define RST_FEN0       8'h3f
`define RST_FEN1       8'h10
`define RST_MSEL0      8'h50
`define RST_MSEL1      8'h05
`define RST_BPTR1      8'h11
`define RST_BPTR2      8'h11

`endif

// File: rtl/can_buffer_filter_regs.v
// buffer setup and acceptance filter registers of a can controller, apb slave
// What this block does
// - buffer length code 0..8 means 0..8 bytes; 9..15 are reserved codes.
// - receive buffer bit 6 shows whether the stored frame was remote.
// - receive layout reads bits 7, 5 and 4 as zero.
// - transmit buffer sends rtr equal to software bit 6.
// - direction bits 7..2 set buffers 5..0 transmit; reset 0; bits 1..0 zero.
// - buffer length registers exist only in modes 1, 2 and 3.
// - filter high byte holds identifier bits 10..3 or 28..21.
// - filter low byte: bits 7..5, 1..0 identifier; bits 4, 2 read zero.
// - filter bit 3 picks extended frames when 1, standard when 0.
// - sixteen filters; filters 6..15 exist only in modes 1, 2 and 3.
// - each mask high byte masks identifier bits 10..3 or 28..21.
// - mask low byte: bits 7..5, 1..0 mask bits; bits 4, 2 read zero.
// - mask bit 3 forces filter frame type when 1; reset 0; zero in mode 0.
// - outside mode 0 a filter takes part only while its enable bit is one; mode 0 uses filters 0..5.
// - per filter selector: mask 0, mask 1, filter 15, or no mask.
// - per filter pointer: two dedicated buffers, buffers 0..5, rest reserved.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "can_buffer_filter_regs_consts.vh"

module can_buffer_filter_regs #(
    parameter NUM_FILTERS = 16,
    parameter NUM_BUFFERS = 6
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [8:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rx_frame_valid,
    input  wire [28:0] rx_frame_ident,
    input  wire        rx_frame_ext,
    input  wire        rx_frame_rtr,
    input  wire [3:0]  rx_frame_dlc,
    output reg         rx_accept,
    output reg  [3:0]  rx_accept_filter,
    output reg  [3:0]  rx_accept_pointer,
    output reg  [5:0]  buffer_tx_direction,
    output reg  [5:0]  tx_remote_request_ctl,
    output reg  [1:0]  op_mode
);

    // ****************************************************************
    // storage
    // ****************************************************************
    reg [7:0] dir_q;
    reg [15:0] fen_q;
    reg [31:0] msel_q;
    reg [63:0] bptr_q;
    reg [7:0] len_q [0:5];
    reg [7:0] f_sidh_q [0:15];
    reg [7:0] f_sidl_q [0:15];
    reg [7:0] f_eidh_q [0:15];
    reg [7:0] f_eidl_q [0:15];
    reg [7:0] m_sidh_q [0:1];
    reg [7:0] m_sidl_q [0:1];
    reg [7:0] m_eidh_q [0:1];
    reg [7:0] m_eidl_q [0:1];

    // mode and word index decode; each offset is relative to its group's base
    wire       enhanced = (op_mode != `MODE_LEGACY);
    wire [6:0] widx     = paddr[8:2];
    wire [6:0] foff     = widx - `IDX_FILT_BASE;
    wire [3:0] fsel     = foff[5:2];
    wire [1:0] fsub     = foff[1:0];
    wire       msel_i   = widx[2];
    wire [1:0] msub     = widx[1:0];
    wire [6:0] loff     = widx - `IDX_LEN_BASE;
    wire [2:0] lsel     = loff[2:0];
    wire [6:0] soff     = widx - `IDX_MSEL_BASE;
    wire [6:0] boff     = widx - `IDX_BPTR_BASE;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // 29-bit identifier image of a filter or mask group
    function [28:0] id_image;
        input [7:0] sidh;
        input [7:0] sidl;
        input [7:0] eidh;
        input [7:0] eidl;
        begin
            id_image = {sidh, sidl[7:5], sidl[1:0], eidh, eidl};
        end
    endfunction

    // one filter against the incoming frame
    function id_match;
        input [28:0] fv;
        input        fext;
        input [28:0] mv;
        input        mext;
        input        enh;
        input        rext;
        input [28:0] rid;
        reg   [28:0] cmp;
        reg   [28:0] em;
        reg          type_ok;
        begin
            cmp = rext ? rid : {rid[10:0], 18'h00000};
            em  = rext ? mv : {mv[28:18], 18'h00000};
            type_ok = (enh && !mext) ? 1'b1 : (fext == rext);
            id_match = type_ok && (((cmp ^ fv) & em) == 29'h0);
        end
    endfunction

    // word index inside an inclusive window of the register map
    function in_window;
        input [6:0] idx;
        input [6:0] lo;
        input [6:0] hi;
        begin
            in_window = (idx >= lo) && (idx <= hi);
        end
    endfunction

    // mask low byte as stored and read: bit 3 only lives in the enhanced modes
    function [7:0] mask_low;
        input [7:0] raw;
        input       enh;
        begin
            mask_low = (raw & `MSKL_WR_MASK) | (raw & ({7'h00, enh} << `IDL_EXT_BIT));
        end
    endfunction

    // register groups, shared by read decode and write decode
    wire       in_msel  = in_window(widx, `IDX_MSEL_BASE, `IDX_MSEL_LAST);
    wire       in_bptr  = in_window(widx, `IDX_BPTR_BASE, `IDX_BPTR_LAST);
    wire       in_len   = in_window(widx, `IDX_LEN_BASE, `IDX_LEN_LAST);
    wire       in_filt  = in_window(widx, `IDX_FILT_BASE, `IDX_FILT_LAST);
    wire       in_mask  = in_window(widx, `IDX_MASK_BASE, `IDX_MASK_LAST);

    // ****************************************************************
    // address decode and read data
    // ****************************************************************
    reg        hit;
    reg [7:0]  rd_byte;
    always @* begin
        hit = 1'b1;
        rd_byte = 8'h00;
        if (widx == `IDX_MODE) begin
            rd_byte = {6'h00, op_mode};
        end else if (widx == `IDX_DIR) begin
            rd_byte = {dir_q[7:`DIR_LSB], 2'b00};
        end else if (widx == `IDX_FEN0) begin
            rd_byte = fen_q[7:0];
        end else if (widx == `IDX_FEN1) begin
            rd_byte = fen_q[15:8];
        end else if (in_msel) begin
            rd_byte = msel_q[soff[1:0]*8 +: 8];
        end else if (in_bptr) begin
            rd_byte = bptr_q[boff[2:0]*8 +: 8];
        end else if (in_len && enhanced) begin
            rd_byte = {1'b0, len_q[lsel][`LEN_RTR_BIT], 2'b00, len_q[lsel][3:0]};
        end else if (in_filt
                     && (enhanced || fsel < `LEGACY_FILTERS)) begin
            case (fsub)
                `SUB_SIDH: rd_byte = f_sidh_q[fsel];
                `SUB_SIDL: rd_byte = f_sidl_q[fsel] & `IDL_WR_MASK;
                `SUB_EIDH: rd_byte = f_eidh_q[fsel];
                default:   rd_byte = f_eidl_q[fsel];
            endcase
        end else if (in_mask) begin
            case (msub)
                `SUB_SIDH: rd_byte = m_sidh_q[msel_i];
                `SUB_SIDL: rd_byte = mask_low(m_sidl_q[msel_i], enhanced);
                `SUB_EIDH: rd_byte = m_eidh_q[msel_i];
                default:   rd_byte = m_eidl_q[msel_i];
            endcase
        end else begin
            hit = 1'b0;
        end
    end

    // ****************************************************************
    // acceptance
    // ****************************************************************
    reg        acc_any;
    reg [3:0]  acc_f;
    reg [28:0] mv;
    reg        mext;
    integer    i;
    always @* begin
        acc_any = 1'b0;
        acc_f   = 4'h0;
        mv      = 29'h0;
        mext    = 1'b0;
        // highest filter first so the lowest number wins
        for (i = NUM_FILTERS - 1; i >= 0; i = i - 1) begin
            case (msel_q[i*2 +: 2])
                `MSEL_MASK0: begin
                    mv   = id_image(m_sidh_q[0], m_sidl_q[0], m_eidh_q[0], m_eidl_q[0]);
                    mext = m_sidl_q[0][`IDL_EXT_BIT];
                end
                `MSEL_MASK1: begin
                    mv   = id_image(m_sidh_q[1], m_sidl_q[1], m_eidh_q[1], m_eidl_q[1]);
                    mext = m_sidl_q[1][`IDL_EXT_BIT];
                end
                `MSEL_FILT15: begin
                    mv   = id_image(f_sidh_q[15], f_sidl_q[15], f_eidh_q[15], f_eidl_q[15]);
                    mext = f_sidl_q[15][`IDL_EXT_BIT];
                end
                default: begin
                    mv   = 29'h0;
                    mext = 1'b0;
                end
            endcase
            if ((enhanced ? fen_q[i] : (i < `LEGACY_FILTERS))
                && id_match(id_image(f_sidh_q[i], f_sidl_q[i], f_eidh_q[i], f_eidl_q[i]),
                            f_sidl_q[i][`IDL_EXT_BIT], mv, mext, enhanced,
                            rx_frame_ext, rx_frame_ident)) begin
                acc_any = 1'b1;
                acc_f   = i[3:0];
            end
        end
    end

    // capture needs a receive buffer, a length write a transmit one: they never collide
    wire [3:0] acc_ptr  = bptr_q[acc_f*4 +: 4];
    wire [3:0] ptr_buf  = acc_ptr - `BUF_PTR_FIRST;
    wire       to_prog  = acc_ptr >= `BUF_PTR_FIRST && acc_ptr <= `BUF_PTR_LAST;
    wire       rx_store = rx_frame_valid && acc_any && to_prog && enhanced
                          && !dir_q[`DIR_LSB + ptr_buf[2:0]];

    // ****************************************************************
    // apb handshake, one wait state
    // ****************************************************************
    // pready drops after one cycle so a setup may follow the completing edge at once
    wire access = psel && penable;
    wire commit = access && pready;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= access && !pready;
            prdata  <= (access && !pready && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
            pslverr <= access && !pready && !hit; // unmapped or hidden in mode 0
        end
    end

    // ****************************************************************
    // register writes and frame capture
    // ****************************************************************
    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode <= `MODE_LEGACY;
            dir_q   <= 8'h00;
            fen_q   <= {`RST_FEN1, `RST_FEN0};
            msel_q  <= {16'h0000, `RST_MSEL1, `RST_MSEL0};
            bptr_q  <= {40'h0000000000, `RST_BPTR2, `RST_BPTR1, 8'h00};
            // contents below are undefined to software; zero is only a choice
            for (k = 0; k < NUM_BUFFERS; k = k + 1) begin
                len_q[k] <= 8'h00;
            end
            for (k = 0; k < NUM_FILTERS; k = k + 1) begin
                f_sidh_q[k] <= 8'h00;
                f_sidl_q[k] <= 8'h00;
                f_eidh_q[k] <= 8'h00;
                f_eidl_q[k] <= 8'h00;
            end
            for (k = 0; k < 2; k = k + 1) begin
                m_sidh_q[k] <= 8'h00;
                m_sidl_q[k] <= 8'h00;
                m_eidh_q[k] <= 8'h00;
                m_eidl_q[k] <= 8'h00;
            end
        end else begin
            // captured frame in a receive buffer; software cannot write it then
            if (rx_store) begin
                len_q[ptr_buf[2:0]] <= {1'b0, rx_frame_rtr, 2'b00, rx_frame_dlc};
            end
            if (commit && pwrite && hit) begin
                if (widx == `IDX_MODE) begin
                    op_mode <= pwdata[1:0];
                end else if (widx == `IDX_DIR) begin
                    dir_q <= {pwdata[7:`DIR_LSB], 2'b00};
                end else if (widx == `IDX_FEN0) begin
                    fen_q[7:0] <= pwdata[7:0];
                end else if (widx == `IDX_FEN1) begin
                    fen_q[15:8] <= pwdata[7:0];
                end else if (in_msel) begin
                    msel_q[soff[1:0]*8 +: 8] <= pwdata[7:0];
                end else if (in_bptr) begin
                    bptr_q[boff[2:0]*8 +: 8] <= pwdata[7:0];
                end else if (in_len) begin
                    if (dir_q[`DIR_LSB + lsel]) begin
                        len_q[lsel] <= {1'b0, pwdata[`LEN_RTR_BIT], 2'b00, pwdata[3:0]};
                    end
                end else if (in_filt) begin
                    case (fsub)
                        `SUB_SIDH: f_sidh_q[fsel] <= pwdata[7:0];
                        `SUB_SIDL: f_sidl_q[fsel] <= pwdata[7:0] & `IDL_WR_MASK;
                        `SUB_EIDH: f_eidh_q[fsel] <= pwdata[7:0];
                        default:   f_eidl_q[fsel] <= pwdata[7:0];
                    endcase
                end else begin
                    case (msub)
                        `SUB_SIDH: m_sidh_q[msel_i] <= pwdata[7:0];
                        `SUB_SIDL: m_sidl_q[msel_i] <= mask_low(pwdata[7:0], enhanced);
                        `SUB_EIDH: m_eidh_q[msel_i] <= pwdata[7:0];
                        default:   m_eidl_q[msel_i] <= pwdata[7:0];
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // registered status and transmit controls
    // ****************************************************************
    integer b;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_accept             <= 1'b0;
            rx_accept_filter      <= 4'h0;
            rx_accept_pointer     <= 4'h0;
            buffer_tx_direction   <= 6'h00;
            tx_remote_request_ctl <= 6'h00;
        end else begin
            rx_accept           <= rx_frame_valid && acc_any;
            rx_accept_filter    <= acc_f;
            rx_accept_pointer   <= acc_ptr;
            buffer_tx_direction <= dir_q[7:`DIR_LSB];
            for (b = 0; b < NUM_BUFFERS; b = b + 1) begin
                tx_remote_request_ctl[b] <= dir_q[`DIR_LSB + b] && len_q[b][`LEN_RTR_BIT];
            end
        end
    end

endmodule // can_buffer_filter_regs
`default_nettype wire

// File: verification/can_buffer_filter_regs_assertions.sv
// concurrent checks on the apb and frame ports of the filter register block
`timescale 1ns/10ps
`default_nettype none
`include "can_buffer_filter_regs_consts.vh"
module can_buffer_filter_regs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [8:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_frame_valid,
    input wire logic        rx_accept,
    input wire logic [5:0]  buffer_tx_direction,
    input wire logic [1:0]  op_mode
);
    // completed transfer and address decode
    wire       acc = psel && penable && pready;
    wire [6:0] idx = paddr[8:2];
    wire       rd  = acc && !pwrite && !pslverr;
    wire       lo  = paddr[3:2] == `SUB_SIDL;
    wire       len = idx >= `IDX_LEN_BASE && idx <= `IDX_LEN_LAST;
    wire       flt = idx >= `IDX_FILT_BASE && idx <= `IDX_FILT_LAST;
    wire       msk = idx >= `IDX_MASK_BASE && idx <= `IDX_MASK_LAST;
    wire       hid = idx >= `IDX_FILT_BASE + 7'd24 && idx <= `IDX_FILT_LAST;
    logic [5:0] dir_q;
    // last direction word written, to judge the port copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dir_q <= 6'h00;
        else if (acc && pwrite && idx == `IDX_DIR)
            dir_q <= pwdata[7:2];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_dir_wr; acc && pwrite && idx == `IDX_DIR |=> ##[0:1] buffer_tx_direction == dir_q;
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direction port not updated");
    property p_dir_rd; rd && idx == `IDX_DIR |-> prdata[7:0] == {buffer_tx_direction, 2'b00};
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction read wrong");
    property p_len_rd; rd && len |-> !prdata[7] && prdata[5:4] == 2'b00; endproperty
    a_len_rd: assert property (p_len_rd) else $error("length zero bits set");
    property p_len_m0; acc && op_mode == `MODE_LEGACY && len |-> pslverr; endproperty
    a_len_m0: assert property (p_len_m0) else $error("length reachable in mode 0");
    property p_flt_m0; acc && op_mode == `MODE_LEGACY && hid |-> pslverr; endproperty
    a_flt_m0: assert property (p_flt_m0) else $error("upper filter in mode 0");
    property p_flt_lo; rd && flt && lo |-> prdata[4] == 1'b0 && prdata[2] == 1'b0; endproperty
    a_flt_lo: assert property (p_flt_lo) else $error("filter low zero bits set");
    property p_msk_lo; rd && msk && lo |-> prdata[4] == 1'b0 && prdata[2] == 1'b0; endproperty
    a_msk_lo: assert property (p_msk_lo) else $error("mask low zero bits set");
    property p_msk_m0; rd && msk && lo && op_mode == `MODE_LEGACY |-> !prdata[3]; endproperty
    a_msk_m0: assert property (p_msk_m0) else $error("mask type bit in mode 0");
    property p_acc; rx_accept |-> $past(rx_frame_valid); endproperty
    a_acc: assert property (p_acc) else $error("accept without frame");
    c_err: cover property (acc && pslverr);
    c_acc: cover property (rx_accept);
    c_dir: cover property (acc && pwrite && idx == `IDX_DIR);
endmodule // can_buffer_filter_regs_chk
`default_nettype wire

// File: verification/can_frame_source.sv
// model of the protocol engine handing received frames to the filters
`timescale 1ns/10ps
`default_nettype none
module can_frame_source (
    input  wire logic        pclk,
    output var  logic        valid,
    output var  logic [28:0] ident,
    output var  logic        ext,
    output var  logic        rtr,
    output var  logic [3:0]  dlc
);
    initial begin
        valid = 1'b0;
        ident = 29'h0;
        ext   = 1'b0;
        rtr   = 1'b0;
        dlc   = 4'h0;
    end
    // one-cycle frame, lines scrambled once it is gone
    task automatic send(input logic [28:0] i, input logic e, input logic r, input logic [3:0] d);
        @(posedge pclk);
        valid <= 1'b1;
        ident <= i;
        ext   <= e;
        rtr   <= r;
        dlc   <= d;
        @(posedge pclk);
        valid <= 1'b0;
        ident <= ~i;
        ext   <= ~e;
        rtr   <= ~r;
        dlc   <= ~d;
    endtask
endmodule // can_frame_source
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the buffer and filter register block
`timescale 1ns/10ps
`default_nettype none
`include "can_buffer_filter_regs_consts.vh"
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [8:0] paddr = 9'h0;
    logic [31:0] pwdata = 32'h0, rdv;
    logic err;
    wire [31:0] prdata;
    wire pready, pslverr, fv, fe, fr, rx_accept;
    wire [28:0] fi;
    wire [3:0] fd, rx_accept_filter, rx_accept_pointer;
    wire [5:0] buffer_tx_direction, tx_remote_request_ctl;
    wire [1:0] op_mode;
    int failures = 0, num_checks = 0;
    logic [6:0] ri [8] = '{`IDX_MODE, `IDX_DIR, `IDX_FEN0, `IDX_FEN1, 7'h04, 7'h05, 7'h09, 7'h0a};
    logic [7:0] rv [8] = '{8'h00, 8'h00, `RST_FEN0, `RST_FEN1, `RST_MSEL0, `RST_MSEL1,
                           `RST_BPTR1, `RST_BPTR2};
    localparam logic [28:0] XID = {8'ha5, 3'b001, 2'b01, 8'h3c, 8'h5a};
    always #25 pclk = ~pclk;
    can_buffer_filter_regs i_can_buffer_filter_regs (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame_valid(fv),
        .rx_frame_ident(fi), .rx_frame_ext(fe), .rx_frame_rtr(fr), .rx_frame_dlc(fd),
        .rx_accept(rx_accept), .rx_accept_filter(rx_accept_filter),
        .rx_accept_pointer(rx_accept_pointer), .buffer_tx_direction(buffer_tx_direction),
        .tx_remote_request_ctl(tx_remote_request_ctl), .op_mode(op_mode));
    can_frame_source i_can_frame_source (.pclk(pclk), .valid(fv), .ident(fi), .ext(fe),
        .rtr(fr), .dlc(fd));
    task automatic conclude();
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [6:0] i, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk("pready", 32'h1, 32'h0);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        xfer(1'b1, i, d);
    endtask
    task automatic rchk(input logic [6:0] i, input logic [7:0] e, input logic x);
        xfer(1'b0, i, 8'h00);
        chk("pslverr", 32'(x), 32'(err));
        chk("prdata", {24'h0, e}, rdv);
    endtask
    task automatic fr_chk(input logic [28:0] i, input logic e, input logic r, input logic [3:0] d,
                          input logic a, input logic [3:0] f);
        i_can_frame_source.send(i, e, r, d);
        #1;
        chk("rx_accept", 32'(a), 32'(rx_accept));
        if (a)
            chk("rx_accept_filter", 32'(f), 32'(rx_accept_filter));
    endtask
    initial begin
        #1000000;
        failures++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) rchk(ri[k], rv[k], 1'b0);
        rchk(`IDX_LEN_BASE, 8'h00, 1'b1);
        rchk(`IDX_FILT_BASE + 7'd24, 8'h00, 1'b1);
        rchk(7'h7f, 8'h00, 1'b1);
        wr(7'h04, 8'h00);
        wr(7'h05, 8'h00);
        for (int k = 0; k < 4; k++) wr(`IDX_MASK_BASE + 7'(k), 8'hff);
        rchk(`IDX_MASK_BASE + 7'd1, 8'he3, 1'b0);
        for (int k = 4; k < 24; k++) wr(`IDX_FILT_BASE + 7'(k), 8'h00);
        wr(`IDX_FILT_BASE, 8'h12);
        wr(`IDX_FILT_BASE + 7'd1, 8'hff);
        rchk(`IDX_FILT_BASE + 7'd1, 8'heb, 1'b0);
        wr(`IDX_FILT_BASE + 7'd1, 8'h40);
        rchk(`IDX_FILT_BASE, 8'h12, 1'b0);
        fr_chk(29'h092, 1'b0, 1'b0, 4'h1, 1'b1, 4'h0);
        fr_chk(29'h093, 1'b0, 1'b0, 4'h1, 1'b0, 4'h0);
        fr_chk(29'h092, 1'b1, 1'b0, 4'h1, 1'b0, 4'h0);
        wr(`IDX_FILT_BASE + 7'd4, 8'ha5);
        wr(`IDX_FILT_BASE + 7'd5, 8'h29);
        wr(`IDX_FILT_BASE + 7'd6, 8'h3c);
        wr(`IDX_FILT_BASE + 7'd7, 8'h5a);
        fr_chk(XID, 1'b1, 1'b0, 4'h2, 1'b1, 4'h1);
        wr(`IDX_MODE, 8'h01);
        wr(`IDX_FEN1, 8'h00);
        chk("op_mode", 32'h1, 32'(op_mode));
        wr(`IDX_MASK_BASE + 7'd1, 8'hff);
        rchk(`IDX_MASK_BASE + 7'd1, 8'heb, 1'b0);
        for (int k = 4; k < 8; k++) wr(`IDX_MASK_BASE + 7'(k), 8'h00);
        for (int k = 60; k < 64; k++) wr(`IDX_FILT_BASE + 7'(k), 8'h00);
        for (int c = 3; c >= 0; c--) begin
            wr(7'h04, 8'(c << 2));
            fr_chk(XID ^ 29'h1, 1'b1, 1'b0, 4'h0, c != 0, 4'h1);
        end
        wr(`IDX_FEN0, 8'h3d);
        fr_chk(XID, 1'b1, 1'b0, 4'h0, 1'b0, 4'h0);
        wr(`IDX_FEN0, 8'h3f);
        wr(`IDX_BPTR_BASE, 8'h30);
        fr_chk(XID, 1'b1, 1'b1, 4'h8, 1'b1, 4'h1);
        chk("rx_accept_pointer", 32'h3, 32'(rx_accept_pointer));
        rchk(`IDX_LEN_BASE + 7'd1, 8'h48, 1'b0);
        fr_chk(XID, 1'b1, 1'b0, 4'h4, 1'b1, 4'h1);
        rchk(`IDX_LEN_BASE + 7'd1, 8'h04, 1'b0);
        wr(`IDX_DIR, 8'h08);
        rchk(`IDX_DIR, 8'h08, 1'b0);
        chk("buffer_tx_direction", 32'h2, 32'(buffer_tx_direction));
        wr(`IDX_LEN_BASE + 7'd1, 8'hff);
        rchk(`IDX_LEN_BASE + 7'd1, 8'h4f, 1'b0);
        chk("tx_remote_request_ctl", 32'h1, 32'(tx_remote_request_ctl[1]));
        wr(`IDX_LEN_BASE + 7'd1, 8'h09);
        rchk(`IDX_LEN_BASE + 7'd1, 8'h09, 1'b0);
        chk("tx_remote_request_ctl", 32'h0, 32'(tx_remote_request_ctl[1]));
        wr(`IDX_DIR, 8'hff);
        rchk(`IDX_DIR, 8'hfc, 1'b0);
        conclude();
    end
endmodule // tb_top
bind can_buffer_filter_regs can_buffer_filter_regs_chk i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame_valid(rx_frame_valid),
    .rx_accept(rx_accept), .buffer_tx_direction(buffer_tx_direction), .op_mode(op_mode));
`default_nettype wire
